/* File: pkg/sle_pkg.sv */
package sle_pkg;
	localparam int unsigned DW = 16;
	localparam logic [3:0] SP_IDX = 4'hf;
	localparam logic [15:0] STK_FLOOR = 16'h0800;
	localparam logic [15:0] SP_RESET = 16'h0800;
	localparam logic [15:0] STK_STEP = 16'h0002;
	localparam logic [15:0] OFS_SP = 16'h001e;
	localparam logic [15:0] OFS_STACK_LIMIT_REGISTER = 16'h0020;
	localparam logic [15:0] OFS_BSR = 16'h0750;
	localparam logic [15:0] OFS_SSR = 16'h0752;
	localparam int unsigned CTL_W = 3;
	localparam int unsigned BIT_LOCK = 0;
	localparam int unsigned BIT_IRD = 1;
	localparam int unsigned BIT_IWR = 2;
	localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;
	localparam int unsigned FILE_AW = 13;
	localparam int unsigned LIT_S_W = 5;
	localparam int unsigned LIT_L_W = 10;
	localparam int unsigned PCH_W = 7;

	typedef enum logic [3:0] {
		M_FILE,
		M_DIRECT,
		M_IND,
		M_POST,
		M_PRE,
		M_INDEX,
		M_LITOFS,
		M_LIT5,
		M_LIT10
	} sle_mode_t;

	typedef enum logic [1:0] {
		PUSH_DATA,
		PUSH_CALL_HI,
		PUSH_EXC_HI
	} sle_push_t;
endpackage

/* File: design/sle_unit.sv */
`timescale 1ns/1ps
// What this block does
// - working register fifteen doubles as stack pointer
// - pointer names next free word, grows upward
// - push writes then increments, pop decrements then reads
// - call push clears top bit of word
// - exception push puts status byte above pc
// - stack limit has no reset value
// - stack limit bit zero forced to zero
// - stack pointer addresses compared against limit
// - push at limit passes, next one traps
// - stack address below floor traps underflow
// - boot secure ram only for boot code on indirect accesses; direct ones are not checked
// - segment secure ram only for secure code on indirect accesses; direct ones are not checked
// - control registers three bits, reset zero
// - control registers absent on smallest variant
// - file direct address thirteen bits wide
// - operand one direct, operand two varied
// - literals are five or ten bits wide
// - indirect mode uses pointer unchanged
// - post-modify uses pointer, then adjusts it
// - pre-modify adjusts pointer, then uses it
// - indexed adds base, literal offset adds literal
module sle_unit
	import sle_pkg::*;
#(
	parameter bit          HAS_SEC = 1'b1,
	parameter logic [15:0] BRAM_LO = 16'h0800,
	parameter logic [15:0] BRAM_HI = 16'h08ff,
	parameter logic [15:0] SRAM_LO = 16'h0900,
	parameter logic [15:0] SRAM_HI = 16'h09ff
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic [15:0]           reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [15:0]                reg_rdata,
	input  wire logic                  ea_req,
	input  wire sle_pkg::sle_mode_t    ea_mode,
	input  wire logic [3:0]            ea_ptr_sel,
	input  wire logic [15:0]           ea_ptr_val,
	input  wire logic [15:0]           ea_base_val,
	input  wire logic [3:0]            ea_op1_sel,
	input  wire logic [9:0]            ea_lit,
	input  wire logic signed [4:0]     ea_mod,
	input  wire logic [12:0]           ea_faddr,
	input  wire logic                  ea_is_wr,
	output logic [15:0]                ea_addr_q,
	output logic                       ea_valid_q,
	output logic [15:0]                ea_lit_q,
	output logic                       ea_lit_valid_q,
	output logic [3:0]                 ea_op1_q,
	output logic [15:0]                ea_wb_val_q,
	output logic                       ea_wb_en_q,
	input  wire logic                  stk_push,
	input  wire logic                  stk_pop,
	input  wire sle_pkg::sle_push_t    stk_kind,
	input  wire logic [15:0]           stk_data,
	input  wire logic [6:0]            pc_hi,
	input  wire logic [7:0]            status_low_byte,
	output logic [15:0]                mem_addr_q,
	output logic [15:0]                mem_wdata_q,
	output logic                       mem_we_q,
	output logic                       mem_re_q,
	output logic [15:0]                sp_q,
	output logic                       stk_err_trap_q,
	input  wire logic                  acc_req,
	input  wire logic                  acc_wr,
	input  wire logic                  acc_ind,
	input  wire logic [15:0]           acc_addr,
	input  wire logic                  exec_boot,
	input  wire logic                  exec_secure,
	output logic                       acc_deny_q
);
	import sle_pkg::*;

	if (BRAM_LO > BRAM_HI || SRAM_LO > SRAM_HI ||
	    !(BRAM_HI < SRAM_LO || SRAM_HI < BRAM_LO)) begin : g_chk
		$error("secure ram windows must be ordered and disjoint");
	end

	logic [15:1]       stack_limit_register_hi;
	logic [15:0]       stack_limit_register;
	logic [CTL_W-1:0]  bsr_q;
	logic [CTL_W-1:0]  ssr_q;
	logic [15:0]       ptr;
	logic [15:0]       ea_d;
	logic [15:0]       wb_d;
	logic              wb_en_d;
	logic [15:0]       lit_d;
	logic              lit_en_d;
	logic              ea_on_d;
	logic [15:0]       sp_d;
	logic              sp_upd;
	logic [15:0]       chk_addr;
	logic              chk_on;
	logic              err_d;
	logic [15:0]       push_word;
	logic [15:0]       mod_ext;
	logic              stk_op;
	logic              uses_sp;

	// bit zero is never stored, so no alignment slip can reach it
	assign stack_limit_register = {stack_limit_register_hi, 1'b0};

	// no reset branch: limit stays unknown until software loads it
	always_ff @(posedge mclk) begin
		if (reg_wr && reg_addr == OFS_STACK_LIMIT_REGISTER) begin
			stack_limit_register_hi <= reg_wdata[15:1];
		end
	end

	// the lock bit freezes a control register until the next reset
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bsr_q <= CTL_RESET;
			ssr_q <= CTL_RESET;
		end else if (HAS_SEC && reg_wr) begin
			if (reg_addr == OFS_BSR && !bsr_q[BIT_LOCK]) begin
				bsr_q <= reg_wdata[CTL_W-1:0];
			end
			if (reg_addr == OFS_SSR && !ssr_q[BIT_LOCK]) begin
				ssr_q <= reg_wdata[CTL_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_SP: reg_rdata <= sp_q;
				OFS_STACK_LIMIT_REGISTER: reg_rdata <= stack_limit_register;
				OFS_BSR: reg_rdata <= HAS_SEC ?
				    {13'h0000, bsr_q} : 16'h0000;
				OFS_SSR: reg_rdata <= HAS_SEC ?
				    {13'h0000, ssr_q} : 16'h0000;
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	assign stk_op = stk_push || stk_pop;
	assign uses_sp = ea_ptr_sel == SP_IDX;
	assign ptr = uses_sp ? sp_q : ea_ptr_val;
	assign mod_ext = {{11{ea_mod[4]}}, ea_mod};

	// high word of pc pushes: bit 15 stays clear for calls
	always_comb begin
		unique case (stk_kind)
			PUSH_CALL_HI: push_word = {9'h000, pc_hi};
			PUSH_EXC_HI: push_word = {status_low_byte, 1'b0, pc_hi};
			default: push_word = stk_data;
		endcase
	end

	// a stack op takes the cycle; an address request beside it is dropped
	always_comb begin
		ea_d = 16'h0000;
		wb_d = ptr;
		wb_en_d = 1'b0;
		lit_d = 16'h0000;
		lit_en_d = 1'b0;
		ea_on_d = 1'b0;
		if (ea_req && !stk_op) begin
			ea_on_d = 1'b1;
			unique case (ea_mode)
				M_FILE: ea_d = {3'h0, ea_faddr};
				M_DIRECT: ea_on_d = 1'b0;
				M_IND: ea_d = ptr;
				M_POST: begin
					ea_d = ptr;
					wb_d = ptr + mod_ext;
					wb_en_d = 1'b1;
				end
				M_PRE: begin
					ea_d = ptr + mod_ext;
					wb_d = ptr + mod_ext;
					wb_en_d = 1'b1;
				end
				M_INDEX: ea_d = ptr + ea_base_val;
				M_LITOFS: ea_d = ptr + {6'h00, ea_lit};
				M_LIT5: begin
					ea_on_d = 1'b0;
					lit_d = {11'h000, ea_lit[LIT_S_W-1:0]};
					lit_en_d = 1'b1;
				end
				M_LIT10: begin
					ea_on_d = 1'b0;
					lit_d = {6'h00, ea_lit[LIT_L_W-1:0]};
					lit_en_d = 1'b1;
				end
				default: ea_on_d = 1'b0;
			endcase
		end
	end

	// stack moves and pointer write-backs through register fifteen
	always_comb begin
		sp_d = sp_q;
		sp_upd = 1'b0;
		chk_addr = ea_d;
		chk_on = 1'b0;
		if (stk_push) begin
			chk_addr = sp_q;
			sp_d = sp_q + STK_STEP;
			sp_upd = 1'b1;
			chk_on = 1'b1;
		end else if (stk_pop) begin
			chk_addr = sp_q - STK_STEP;
			sp_d = sp_q - STK_STEP;
			sp_upd = 1'b1;
			chk_on = 1'b1;
		end else if (ea_on_d && uses_sp && ea_mode != M_FILE) begin
			chk_on = 1'b1;
			if (wb_en_d) begin
				sp_d = {wb_d[15:1], 1'b0};
				sp_upd = 1'b1;
			end
		end
	end

	// overflow and underflow share one request line
	assign err_d = chk_on && (chk_addr > stack_limit_register ||
	    chk_addr < STK_FLOOR);

	// a core update of the pointer beats a register write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sp_q <= SP_RESET;
		end else if (sp_upd) begin
			sp_q <= sp_d;
		end else if (reg_wr && reg_addr == OFS_SP) begin
			sp_q <= {reg_wdata[15:1], 1'b0};
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stk_err_trap_q <= 1'b0;
		end else begin
			stk_err_trap_q <= err_d;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 16'h0000;
			mem_we_q <= 1'b0;
			mem_re_q <= 1'b0;
		end else begin
			mem_we_q <= stk_push;
			mem_re_q <= stk_pop && !stk_push;
			if (stk_op) begin
				mem_addr_q <= chk_addr;
			end
			if (stk_push) begin
				mem_wdata_q <= push_word;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ea_addr_q <= 16'h0000;
			ea_valid_q <= 1'b0;
			ea_lit_q <= 16'h0000;
			ea_lit_valid_q <= 1'b0;
			ea_op1_q <= 4'h0;
			ea_wb_val_q <= 16'h0000;
			ea_wb_en_q <= 1'b0;
		end else begin
			ea_valid_q <= ea_on_d;
			ea_lit_valid_q <= lit_en_d;
			ea_wb_en_q <= wb_en_d && !uses_sp;
			if (ea_req && !stk_op) begin
				ea_addr_q <= ea_d;
				ea_lit_q <= lit_d;
				ea_op1_q <= ea_op1_sel;
				ea_wb_val_q <= wb_d;
			end
		end
	end

	logic in_b;
	logic in_s;
	logic deny_d;

	assign in_b = acc_addr >= BRAM_LO && acc_addr <= BRAM_HI;
	assign in_s = acc_addr >= SRAM_LO && acc_addr <= SRAM_HI;

	// only indirect accesses are policed; direct ones bypass the window
	always_comb begin
		deny_d = 1'b0;
		if (HAS_SEC && acc_req && acc_ind) begin
			if (in_b && !exec_boot) begin
				deny_d = acc_wr ? bsr_q[BIT_IWR] : bsr_q[BIT_IRD];
			end
			if (in_s && !exec_secure) begin
				deny_d = acc_wr ? ssr_q[BIT_IWR] : ssr_q[BIT_IRD];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc_deny_q <= 1'b0;
		end else begin
			acc_deny_q <= deny_d;
		end
	end

	logic [15:0] pre_sum;
	assign pre_sum = ea_ptr_val + mod_ext;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	push_step_a: assert property (stk_push |=>
	    sp_q == $past(sp_q) + STK_STEP && mem_we_q &&
	    mem_addr_q == $past(sp_q))
		else $error("push did not write then step up");

	pop_step_a: assert property (stk_pop && !stk_push |=>
	    mem_re_q && mem_addr_q == sp_q &&
	    sp_q == $past(sp_q) - STK_STEP)
		else $error("pop did not step down before read");

	lim_equal_a: assert property (stk_push && sp_q == stack_limit_register &&
	    sp_q >= STK_FLOOR |=> !stk_err_trap_q ##1 1'b1)
		else $error("push at the limit trapped");

	lim_over_a: assert property (stk_push && sp_q > stack_limit_register
	    |=> stk_err_trap_q)
		else $error("push past the limit missed trap");

	floor_trap_a: assert property (stk_pop && !stk_push &&
	    sp_q < STK_FLOOR + STK_STEP |=> stk_err_trap_q)
		else $error("underflow below floor missed trap");

	call_msb_a: assert property (stk_push &&
	    stk_kind == PUSH_CALL_HI |=> mem_we_q && !mem_wdata_q[15])
		else $error("call push left top bit set");

	exc_srl_a: assert property (stk_push && stk_kind == PUSH_EXC_HI
	    |=> mem_wdata_q[15:8] == $past(status_low_byte))
		else $error("exception push lost status byte");

	boot_deny_a: assert property (HAS_SEC && acc_req && acc_ind &&
	    in_b && !exec_boot && acc_wr && bsr_q[BIT_IWR] |=> acc_deny_q)
		else $error("boot ram write from outside not denied");

	sec_allow_a: assert property (acc_req && in_s && exec_secure
	    |=> !acc_deny_q)
		else $error("secure code refused its own ram");

	ctl_read_a: assert property (reg_rd && reg_addr == OFS_BSR
	    |=> reg_rdata[15:3] == 13'h0000 &&
	    reg_rdata[2:0] == (HAS_SEC ? $past(bsr_q) : 3'h0))
		else $error("control register read wrong");

	file_ea_a: assert property (ea_req && !stk_op &&
	    ea_mode == M_FILE |=> ea_valid_q && ea_addr_q[15:13] == 3'h0)
		else $error("file address escaped near space");

	pre_mod_a: assert property (ea_req && !stk_op &&
	    ea_mode == M_PRE && !uses_sp |=> ea_addr_q == $past(pre_sum)
	    && ea_wb_en_q && ea_wb_val_q == ea_addr_q)
		else $error("pre-modify address wrong");

	post_mod_a: assert property (ea_req && !stk_op &&
	    ea_mode == M_POST && !uses_sp |=>
	    ea_addr_q == $past(ea_ptr_val) && ea_wb_val_q == $past(pre_sum))
		else $error("post-modify address wrong");
endmodule

/* File: bench/sle_core_mem_model.sv */
`timescale 1ns/1ps
module sle_core_mem_model (
	input  wire logic        mclk,
	input  wire logic [15:0] mem_addr_q,
	input  wire logic [15:0] mem_wdata_q,
	input  wire logic        mem_we_q,
	input  wire logic        mem_re_q,
	output logic [15:0]      rd_data
);
	logic [15:0] mem [0:32767];
	// unwritten words hold an address pattern, so a stray read is visible
	initial begin
		foreach (mem[i]) mem[i] = 16'(i) ^ 16'h5a5a;
	end
	always @(posedge mclk) begin
		if (mem_we_q === 1'b1) mem[mem_addr_q[15:1]] <= mem_wdata_q;
		// idle cycles toggle the read bus instead of holding stale data
		rd_data <= (mem_re_q === 1'b1) ? mem[mem_addr_q[15:1]] : ~rd_data;
	end
endmodule

/* File: bench/sle_unit_tb.sv */
`timescale 1ns/1ps
module sle_unit_tb;
	import sle_pkg::*;
	logic        mclk = 1'b0, resetn = 1'b0;
	logic [15:0] reg_addr = '0, reg_wdata = '0, ea_ptr_val = '0;
	logic [15:0] ea_base_val = '0, stk_data = '0, acc_addr = '0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, ea_req = 1'b0;
	logic        stk_push = 1'b0, stk_pop = 1'b0, acc_req = 1'b0;
	logic        acc_wr = 1'b0, acc_ind = 1'b0;
	logic        exec_boot = 1'b0, exec_secure = 1'b0;
	sle_mode_t   ea_mode = M_FILE, m;
	sle_push_t   stk_kind = PUSH_DATA;
	logic [3:0]  ea_ptr_sel = '0, ea_op1_sel = '0, ea_op1_q, o = '0;
	logic [9:0]  ea_lit = '0, l = '0;
	logic signed [4:0] ea_mod = '0;
	logic [4:0]  md = '0;
	logic [12:0] ea_faddr = '0, f = '0;
	logic [6:0]  pc_hi = '0;
	logic [7:0]  status_low_byte = '0;
	logic [15:0] reg_rdata, ea_addr_q, ea_lit_q, ea_wb_val_q, mem_addr_q;
	logic [15:0] mem_wdata_q, sp_q, rd_data, d[3], p = '0, b = '0, sx;
	logic        ea_valid_q, ea_lit_valid_q, ea_wb_en_q, mem_we_q, mem_re_q;
	logic        stk_err_trap_q, acc_deny_q, rd_s = 0, acc_s = 0, re_s = 0;
	logic [31:0] exp_q[$], e;
	int          n_mismatch = 0, cmp_count = 0, n_trap = 0;

	sle_unit i_dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ea_req, .ea_mode, .ea_ptr_sel, .ea_ptr_val, .ea_base_val,
		.ea_op1_sel, .ea_lit, .ea_mod, .ea_faddr, .ea_is_wr(1'b0), .ea_addr_q,
		.ea_valid_q, .ea_lit_q, .ea_lit_valid_q, .ea_op1_q, .ea_wb_val_q,
		.ea_wb_en_q, .stk_push, .stk_pop, .stk_kind, .stk_data, .pc_hi,
		.status_low_byte, .mem_addr_q, .mem_wdata_q, .mem_we_q, .mem_re_q,
		.sp_q, .stk_err_trap_q, .acc_req, .acc_wr, .acc_ind, .acc_addr,
		.exec_boot, .exec_secure, .acc_deny_q);
	sle_core_mem_model i_mem (.mclk, .mem_addr_q, .mem_wdata_q, .mem_we_q,
		.mem_re_q, .rd_data);

	initial begin
		forever #2 mclk = ~mclk;
	end

	task automatic see(input logic [31:0] g);
		logic [31:0] v;
		cmp_count++;
		v = (exp_q.size() != 0) ? exp_q.pop_front() : ~g;
		if (g !== v) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, v, g);
		end
	endtask

	// results are matched in arrival order; one request is in flight at once
	always @(posedge mclk) begin
		#1;
		if (re_s) see({16'h0, rd_data});
		if (rd_s) see({16'h0, reg_rdata});
		if (ea_valid_q !== 1'b0)
			see({ea_addr_q, (ea_wb_en_q === 1'b1) ? ea_wb_val_q : 16'h0});
		if (ea_lit_valid_q !== 1'b0) see({12'h0, ea_op1_q, ea_lit_q});
		if (mem_we_q !== 1'b0) see({mem_addr_q, mem_wdata_q});
		if (mem_re_q !== 1'b0) see({mem_addr_q, 16'h0});
		if (acc_s) see({31'h0, acc_deny_q});
		// an unknown trap counts too, so it shows up as a count mismatch
		if (stk_err_trap_q !== 1'b0) n_trap++;
		rd_s = reg_rd;
		acc_s = acc_req;
		re_s = (mem_re_q === 1'b1);
	end

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] v);
		exp_q.push_back({16'h0, v});
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	task automatic stk(input logic u, input sle_push_t k,
		input logic [15:0] a, input logic [15:0] v);
		exp_q.push_back({a, u ? v : 16'h0});
		if (!u) exp_q.push_back({16'h0, v});
		@(posedge mclk);
		stk_push <= u;
		stk_pop <= !u;
		stk_kind <= k;
		// pc pushes must not take the data port
		stk_data <= (k == PUSH_DATA) ? v : 16'hffff;
		@(posedge mclk);
		stk_push <= 1'b0;
		stk_pop <= 1'b0;
	endtask

	task automatic ea(input sle_mode_t k, input logic [3:0] s,
		input logic [31:0] v);
		// direct mode answers nothing: any output then is unexpected
		if (k != M_DIRECT) exp_q.push_back(v);
		@(posedge mclk);
		ea_req <= 1'b1;
		ea_mode <= k;
		ea_ptr_sel <= s;
		ea_ptr_val <= p;
		ea_base_val <= b;
		ea_lit <= l;
		ea_mod <= md;
		ea_faddr <= f;
		ea_op1_sel <= o;
		@(posedge mclk);
		ea_req <= 1'b0;
	endtask

	task automatic acc(input logic w, i, input logic [15:0] a,
		input logic bt, sc, v);
		exp_q.push_back({31'h0, v});
		@(posedge mclk);
		acc_req <= 1'b1;
		acc_wr <= w;
		acc_ind <= i;
		acc_addr <= a;
		exec_boot <= bt;
		exec_secure <= sc;
		@(posedge mclk);
		acc_req <= 1'b0;
	endtask

	task automatic tchk(input int n);
		repeat (3) @(posedge mclk);
		cmp_count++;
		if (n_trap != n) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, n, n_trap);
		end
	endtask

	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		n_mismatch++;
		conclude();
	end

	initial begin
		void'($urandom(32'h7b1e));
		foreach (d[i]) d[i] = 16'($urandom);
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		rd(OFS_SP, SP_RESET);
		rd(OFS_BSR, 16'h0000);
		rd(OFS_SSR, 16'h0000);
		wr(OFS_STACK_LIMIT_REGISTER, 16'h0805);
		rd(OFS_STACK_LIMIT_REGISTER, 16'h0804);
		stk(1'b1, PUSH_DATA, 16'h0800, d[0]);
		stk(1'b1, PUSH_DATA, 16'h0802, d[1]);
		stk(1'b1, PUSH_DATA, 16'h0804, d[2]);
		tchk(0);
		pc_hi <= 7'h7f;
		stk(1'b1, PUSH_CALL_HI, 16'h0806, 16'h007f);
		tchk(1);
		pc_hi <= 7'h12;
		status_low_byte <= 8'ha5;
		stk(1'b1, PUSH_EXC_HI, 16'h0808, 16'ha512);
		tchk(2);
		ea(M_IND, 4'hf, {16'h080a, 16'h0000});
		tchk(3);
		wr(OFS_STACK_LIMIT_REGISTER, 16'h0ffe);
		rd(OFS_SP, 16'h080a);
		stk(1'b0, PUSH_DATA, 16'h0808, 16'ha512);
		stk(1'b0, PUSH_DATA, 16'h0806, 16'h007f);
		stk(1'b0, PUSH_DATA, 16'h0804, d[2]);
		stk(1'b0, PUSH_DATA, 16'h0802, d[1]);
		stk(1'b0, PUSH_DATA, 16'h0800, d[0]);
		stk(1'b0, PUSH_DATA, 16'h07fe, 16'h59a5);
		tchk(4);
		wr(OFS_SP, 16'h0900);
		md = 5'h02;
		ea(M_POST, 4'hf, {16'h0900, 16'h0000});
		rd(OFS_SP, 16'h0902);
		md = 5'h1e;
		ea(M_PRE, 4'hf, {16'h0900, 16'h0000});
		rd(OFS_SP, 16'h0900);
		tchk(4);
		wr(OFS_BSR, 16'hfffe);
		rd(OFS_BSR, 16'h0006);
		wr(OFS_SSR, 16'h0006);
		acc(1'b1, 1'b1, 16'h0810, 1'b0, 1'b0, 1'b1);
		acc(1'b0, 1'b1, 16'h08fe, 1'b1, 1'b0, 1'b0);
		acc(1'b1, 1'b0, 16'h0810, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 1'b1, 16'h0900, 1'b1, 1'b0, 1'b1);
		acc(1'b1, 1'b1, 16'h09fe, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b1, 16'h0a00, 1'b0, 1'b0, 1'b0);
		wr(OFS_SSR, 16'h0001);
		wr(OFS_SSR, 16'h0006);
		rd(OFS_SSR, 16'h0001);
		acc(1'b0, 1'b1, 16'h0910, 1'b0, 1'b0, 1'b0);
		rd(16'h0754, 16'h0000);
		for (int i = 0; i < 18; i++) begin
			m = sle_mode_t'(i % 9);
			p = 16'($urandom);
			b = 16'($urandom);
			l = 10'($urandom);
			md = 5'($urandom);
			f = 13'($urandom);
			o = 4'($urandom);
			if (m == M_LITOFS) l[9] = 1'b0;
			sx = p + {{11{md[4]}}, md};
			case (m)
				M_FILE: e = {3'h0, f, 16'h0};
				M_IND: e = {p, 16'h0};
				M_POST: e = {p, sx};
				M_PRE: e = {sx, sx};
				M_INDEX: e = {p + b, 16'h0};
				M_LITOFS: e = {p + {6'h0, l}, 16'h0};
				M_LIT5: e = {12'h0, o, 11'h0, l[4:0]};
				default: e = {12'h0, o, 6'h0, l};
			endcase
			ea(m, 4'($urandom_range(14)), e);
		end
		tchk(4);
		if (exp_q.size() != 0) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, 0, exp_q.size());
		end
		conclude();
	end
endmodule
